/* File: core/tec_pkg.sv */
// Package: trigger event controller constants, enums and register map
package tec_pkg;

  typedef enum logic [2:0] {
    TEC_SRC_HOLD,
    TEC_SRC_IMMEDIATE,
    TEC_SRC_INTERNAL,
    TEC_SRC_BUS,
    TEC_SRC_EXTERNAL,
    TEC_SRC_EXT_ONE,
    TEC_SRC_EXT_TWO
  } tec_src_e;

  typedef enum logic {
    TEC_PORT_ONE,
    TEC_PORT_TWO
  } tec_port_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tec_bus_req_s;

  // Register byte offsets
  localparam logic [7:0] TEC_REG_CTRL      = 8'h00;
  localparam logic [7:0] TEC_REG_HOLDOFF   = 8'h04;
  localparam logic [7:0] TEC_REG_HYST      = 8'h08;
  localparam logic [7:0] TEC_REG_LEVEL     = 8'h0c;
  localparam logic [7:0] TEC_REG_MEAS_LEN  = 8'h10;
  localparam logic [7:0] TEC_REG_DELAY     = 8'h14;
  localparam logic [7:0] TEC_REG_COMMAND   = 8'h18;
  localparam logic [7:0] TEC_REG_STATUS    = 8'h1c;

  // CTRL and COMMAND field positions
  localparam int TEC_CTRL_SRC_LSB    = 0;
  localparam int TEC_CTRL_SRC_MSB    = 2;
  localparam int TEC_CTRL_SLOPE_NEG  = 4;
  localparam int TEC_CTRL_MASTER_EN  = 5;
  localparam int TEC_CTRL_MASTER_PRT = 6;
  localparam int TEC_CTRL_SYNC_EN    = 7;
  localparam int TEC_CTRL_SYNC_PRT   = 8;
  localparam int TEC_CMD_FORCE       = 0;
  localparam int TEC_CMD_INIT        = 1;
  localparam int TEC_CMD_ABORT       = 2;

  // Time base: clock rate and unit scaling (times are programmed in 10 ms units)
  localparam int unsigned TEC_CLK_HZ      = 10_000_000;
  localparam int unsigned TEC_TICK_US     = 10_000;
  localparam int unsigned TEC_TICK_CYCLES = (TEC_CLK_HZ / 1_000_000) * TEC_TICK_US;

  // Hold-off: 0.00 to 10.00 s in 10 ms ticks, reset 0.00 s
  localparam logic [31:0] TEC_HOLDOFF_MAX = 32'h0000_03e8;
  localparam logic [31:0] TEC_HOLDOFF_RST = 32'h0000_0000;
  // Hysteresis: 0.00 to 10.00 dB in 0.01 dB, reset 0.00
  localparam logic [31:0] TEC_HYST_MAX    = 32'h0000_03e8;
  localparam logic [31:0] TEC_HYST_RST    = 32'h0000_0000;
  // Level in nW: 300e-9 W to 100.0e-3 W, reset 3.0e-5 W
  localparam logic [31:0] TEC_LEVEL_MIN   = 32'h0000_012c;
  localparam logic [31:0] TEC_LEVEL_MAX   = 32'h05f5_e100;
  localparam logic [31:0] TEC_LEVEL_RST   = 32'h0000_7530;
  localparam logic [31:0] TEC_MLEN_RST    = 32'h0000_0001;
  localparam logic [31:0] TEC_DELAY_RST   = 32'h0000_0000;
  localparam logic [31:0] TEC_CTRL_RST    = 32'h0000_0001;

endpackage : tec_pkg

/* File: core/tec_trigger_ctrl.sv */
// Trigger event controller: source select, edge detect, hold-off, master and sync outputs
`timescale 1ns/1ps

// Overview of operation
// - Hold-off programmable 0.00 to 10.00 s, reset 0, starts at each accepted trigger.
// - Trigger events arriving while hold-off runs are discarded.
// - Hysteresis 0 to 10 dB: signal must retreat past level before rearming.
// - Force trigger leaves waiting at once, ignoring source and delay.
// - Hold source: only force trigger starts; runs exactly one measurement cycle.
// - Internal source compares power to threshold 300 nW to 100 mW, reset 30 uW.
// - Slope positive means rising, negative falling; reset positive; internal/external only.
// - Source choices hold, immediate, internal, bus, external, ext one, ext two; reset immediate.
// - Master mode drives a pulse synchronous with accepted trigger onto an external port.
// - Master port selects external port one or two; reset port one.
// - Sync port selects port one or two for the sync output; reset port one.
// - Sync enabled holds shared trigger bus blocked while measuring.
module tec_trigger_ctrl #(
  parameter int unsigned TICK_CYCLES = tec_pkg::TEC_TICK_CYCLES,
  parameter int unsigned CNT_W       = 32
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire tec_pkg::tec_bus_req_s bus_req,
  output logic [31:0]               bus_rdata,
  input  wire logic [31:0]          test_power,
  input  wire logic                 bus_trigger,
  input  wire logic                 external_port_one_in,
  input  wire logic                 external_port_two_in,
  input  wire logic [15:0]          average_count,
  output logic                      external_port_one_out,
  output logic                      external_port_one_oe_n,
  output logic                      external_port_two_out,
  output logic                      external_port_two_oe_n,
  output logic                      measuring,
  output logic                      measure_start
);

  initial begin
    if (TICK_CYCLES < 1 || CNT_W < 16 || CNT_W > 32) $error("tec_trigger_ctrl: bad parameters");
  end

  typedef enum logic [1:0] {
    TEC_ST_IDLE,
    TEC_ST_WAIT,
    TEC_ST_DELAY,
    TEC_ST_MEAS
  } tec_state_e;

  tec_state_e        state_q;
  logic [31:0]       ctrl_q;
  logic [31:0]       holdoff_q;
  logic [31:0]       hyst_q;
  logic [31:0]       level_q;
  logic [31:0]       mlen_q;
  logic [31:0]       delay_q;
  logic [CNT_W-1:0]  holdoff_cnt_q;
  logic [CNT_W-1:0]  tick_cnt_q;
  logic [31:0]       phase_cnt_q;
  logic [15:0]       avg_left_q;
  logic              armed_q;
  logic              above_q;
  logic              external_port_one_q;
  logic              external_port_two_q;
  logic              extx_q;
  logic              tick;
  logic              force_cmd;
  logic              init_cmd;
  logic              abort_cmd;
  logic              raw_event;
  logic              accept;
  logic              holdoff_busy;
  logic [31:0]       hyst_band;
  logic [31:0]       level_lo;
  logic [31:0]       level_hi;
  tec_pkg::tec_src_e src;
  logic              slope_neg;
  logic              master_en;
  logic              master_two;
  logic              sync_en;
  logic              sync_two;

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic slope_edge(input logic prev, input logic cur, input logic neg);
    slope_edge = neg ? (prev && !cur) : (!prev && cur);
  endfunction

  assign src        = tec_pkg::tec_src_e'(ctrl_q[tec_pkg::TEC_CTRL_SRC_MSB:tec_pkg::TEC_CTRL_SRC_LSB]);
  assign slope_neg  = ctrl_q[tec_pkg::TEC_CTRL_SLOPE_NEG];
  assign master_en  = ctrl_q[tec_pkg::TEC_CTRL_MASTER_EN];
  assign master_two = ctrl_q[tec_pkg::TEC_CTRL_MASTER_PRT];
  assign sync_en    = ctrl_q[tec_pkg::TEC_CTRL_SYNC_EN];
  assign sync_two   = ctrl_q[tec_pkg::TEC_CTRL_SYNC_PRT];

  assign force_cmd = bus_req.wr && bus_req.addr == tec_pkg::TEC_REG_COMMAND && bus_req.wdata[tec_pkg::TEC_CMD_FORCE];
  assign init_cmd  = bus_req.wr && bus_req.addr == tec_pkg::TEC_REG_COMMAND && bus_req.wdata[tec_pkg::TEC_CMD_INIT];
  assign abort_cmd = bus_req.wr && bus_req.addr == tec_pkg::TEC_REG_COMMAND && bus_req.wdata[tec_pkg::TEC_CMD_ABORT];

  // Register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q    <= tec_pkg::TEC_CTRL_RST;
      holdoff_q <= tec_pkg::TEC_HOLDOFF_RST;
      hyst_q    <= tec_pkg::TEC_HYST_RST;
      level_q   <= tec_pkg::TEC_LEVEL_RST;
      mlen_q    <= tec_pkg::TEC_MLEN_RST;
      delay_q   <= tec_pkg::TEC_DELAY_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == tec_pkg::TEC_REG_CTRL) begin
        ctrl_q <= {23'h000000, bus_req.wdata[8:0]};
      end else if (bus_req.addr == tec_pkg::TEC_REG_HOLDOFF) begin
        holdoff_q <= clamp(bus_req.wdata, 32'h0, tec_pkg::TEC_HOLDOFF_MAX);
      end else if (bus_req.addr == tec_pkg::TEC_REG_HYST) begin
        hyst_q <= clamp(bus_req.wdata, 32'h0, tec_pkg::TEC_HYST_MAX);
      end else if (bus_req.addr == tec_pkg::TEC_REG_LEVEL) begin
        level_q <= clamp(bus_req.wdata, tec_pkg::TEC_LEVEL_MIN, tec_pkg::TEC_LEVEL_MAX);
      end else if (bus_req.addr == tec_pkg::TEC_REG_MEAS_LEN) begin
        mlen_q <= (bus_req.wdata == 32'h0) ? tec_pkg::TEC_MLEN_RST : bus_req.wdata;
      end else if (bus_req.addr == tec_pkg::TEC_REG_DELAY) begin
        delay_q <= bus_req.wdata;
      end
    end
  end

  // Register reads, data one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_rdata <= 32'h0;
    end else if (bus_req.rd) begin
      if (bus_req.addr == tec_pkg::TEC_REG_CTRL) begin
        bus_rdata <= ctrl_q;
      end else if (bus_req.addr == tec_pkg::TEC_REG_HOLDOFF) begin
        bus_rdata <= holdoff_q;
      end else if (bus_req.addr == tec_pkg::TEC_REG_HYST) begin
        bus_rdata <= hyst_q;
      end else if (bus_req.addr == tec_pkg::TEC_REG_LEVEL) begin
        bus_rdata <= level_q;
      end else if (bus_req.addr == tec_pkg::TEC_REG_MEAS_LEN) begin
        bus_rdata <= mlen_q;
      end else if (bus_req.addr == tec_pkg::TEC_REG_DELAY) begin
        bus_rdata <= delay_q;
      end else if (bus_req.addr == tec_pkg::TEC_REG_STATUS) begin
        bus_rdata <= {28'h0000000, armed_q, holdoff_busy, state_q};
      end else begin
        bus_rdata <= 32'h0;
      end
    end else begin
      bus_rdata <= 32'h0;
    end
  end

  // Tick divider: one pulse per time unit, restarted at each accepted event so that
  // hold-off, delay and measuring times are whole multiples of the unit from that event
  always_ff @(posedge core_clk) begin
    if (rst || accept || tick_cnt_q == CNT_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == CNT_W'(TICK_CYCLES - 1));

  // Hysteresis band: 0.01 dB steps approximated as level * hyst / 4343 (linear power ratio)
  assign hyst_band = 32'((64'(level_q) * 64'(hyst_q)) / 64'd4343);
  assign level_hi  = level_q;
  assign level_lo  = (hyst_band >= level_q) ? 32'h0 : level_q - hyst_band;

  // Internal level detector with hysteresis re-arm
  always_ff @(posedge core_clk) begin
    if (rst) begin
      above_q <= 1'b0;
      armed_q <= 1'b1;
    end else begin
      if (!slope_neg) begin
        if (test_power >= level_hi && armed_q) begin
          above_q <= 1'b1;
          armed_q <= 1'b0;
        end else if (test_power < level_lo || (hyst_q == 32'h0 && test_power < level_hi)) begin
          above_q <= 1'b0;
          armed_q <= 1'b1;
        end
      end else begin
        if (test_power < level_lo && armed_q) begin
          above_q <= 1'b0;
          armed_q <= 1'b0;
        end else if (test_power >= level_hi) begin
          above_q <= 1'b1;
          armed_q <= 1'b1;
        end
      end
    end
  end

  // External inputs history for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      external_port_one_q <= 1'b0;
      external_port_two_q <= 1'b0;
      extx_q <= 1'b0;
    end else begin
      external_port_one_q <= external_port_one_in;
      external_port_two_q <= external_port_two_in;
      extx_q <= external_port_one_in | external_port_two_in;
    end
  end

  logic above_prev_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      above_prev_q <= 1'b0;
    end else begin
      above_prev_q <= above_q;
    end
  end

  // Source selection
  always_comb begin
    raw_event = 1'b0;
    case (src)
      tec_pkg::TEC_SRC_HOLD:      raw_event = 1'b0;
      tec_pkg::TEC_SRC_IMMEDIATE: raw_event = 1'b1;
      tec_pkg::TEC_SRC_INTERNAL:  raw_event = slope_edge(above_prev_q, above_q, slope_neg);
      tec_pkg::TEC_SRC_BUS:       raw_event = bus_trigger;
      tec_pkg::TEC_SRC_EXTERNAL:  raw_event = slope_edge(extx_q, external_port_one_in | external_port_two_in, slope_neg);
      tec_pkg::TEC_SRC_EXT_ONE:   raw_event = slope_edge(external_port_one_q, external_port_one_in, slope_neg);
      tec_pkg::TEC_SRC_EXT_TWO:   raw_event = slope_edge(external_port_two_q, external_port_two_in, slope_neg);
      default:                    raw_event = 1'b0;
    endcase
  end

  assign holdoff_busy = (holdoff_cnt_q != '0);
  assign accept       = (state_q == TEC_ST_WAIT) && (force_cmd || (raw_event && !holdoff_busy));

  // Hold-off counter in ticks, started by each accepted event
  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdoff_cnt_q <= '0;
    end else if (accept) begin
      holdoff_cnt_q <= CNT_W'(holdoff_q);
    end else if (tick && holdoff_busy) begin
      holdoff_cnt_q <= holdoff_cnt_q - 1'b1;
    end
  end

  // Measurement sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q     <= TEC_ST_IDLE;
      phase_cnt_q <= 32'h0;
      avg_left_q  <= 16'h0;
    end else if (abort_cmd) begin
      state_q <= TEC_ST_IDLE;
    end else begin
      case (state_q)
        TEC_ST_IDLE: begin
          if (init_cmd) begin
            state_q    <= TEC_ST_WAIT;
            avg_left_q <= (average_count == 16'h0) ? 16'h1 : average_count;
          end
        end
        TEC_ST_WAIT: begin
          if (accept) begin
            if (force_cmd || delay_q == 32'h0) begin
              state_q     <= TEC_ST_MEAS;
              phase_cnt_q <= mlen_q;
              if (force_cmd || src == tec_pkg::TEC_SRC_HOLD) begin
                avg_left_q <= 16'h1;
              end
            end else begin
              state_q     <= TEC_ST_DELAY;
              phase_cnt_q <= delay_q;
            end
          end
        end
        TEC_ST_DELAY: begin
          if (tick) begin
            if (phase_cnt_q <= 32'h1) begin
              state_q     <= TEC_ST_MEAS;
              phase_cnt_q <= mlen_q;
            end else begin
              phase_cnt_q <= phase_cnt_q - 32'h1;
            end
          end
        end
        TEC_ST_MEAS: begin
          if (tick) begin
            if (phase_cnt_q <= 32'h1) begin
              if (avg_left_q <= 16'h1) begin
                state_q <= TEC_ST_IDLE;
              end else begin
                avg_left_q <= avg_left_q - 16'h1;
                state_q    <= TEC_ST_WAIT;
              end
            end else begin
              phase_cnt_q <= phase_cnt_q - 32'h1;
            end
          end
        end
        default: state_q <= TEC_ST_IDLE;
      endcase
    end
  end

  // Registered outputs: master pulse, sync blocking, status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      external_port_one_out  <= 1'b0;
      external_port_one_oe_n <= 1'b1;
      external_port_two_out  <= 1'b0;
      external_port_two_oe_n <= 1'b1;
      measuring              <= 1'b0;
      measure_start          <= 1'b0;
    end else begin
      measuring     <= (state_q == TEC_ST_MEAS);
      measure_start <= accept;
      external_port_one_out  <= (master_en && !master_two && accept) ||
                                (sync_en && !sync_two && state_q == TEC_ST_MEAS);
      external_port_two_out  <= (master_en && master_two && accept) ||
                                (sync_en && sync_two && state_q == TEC_ST_MEAS);
      external_port_one_oe_n <= !((master_en && !master_two) || (sync_en && !sync_two));
      external_port_two_oe_n <= !((master_en && master_two) || (sync_en && sync_two));
    end
  end

endmodule : tec_trigger_ctrl

/* File: tb/tec_far_sensor.sv */
// Far-side model: other equipment sharing the two external trigger lines
`timescale 1ns/1ps
module tec_far_sensor (
  input wire logic far_one_en,
  input wire logic far_one_val,
  input wire logic far_two_en,
  input wire logic far_two_val,
  input wire logic dut_one_out,
  input wire logic dut_one_oe_n,
  input wire logic dut_two_out,
  input wire logic dut_two_oe_n,
  output logic     line_one,
  output logic     line_two
);
  // Lines carry a pull-down, so an undriven line reads low
  assign line_one = !dut_one_oe_n ? dut_one_out : (far_one_en ? far_one_val : 1'b0);
  assign line_two = !dut_two_oe_n ? dut_two_out : (far_two_en ? far_two_val : 1'b0);
endmodule // tec_far_sensor

/* File: tb/tec_trigger_ctrl_asserts.sv */
// Checker: port-level assertions for the trigger event controller
`timescale 1ns/1ps
module tec_chk #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned CNT_W       = 32
) (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire tec_pkg::tec_bus_req_s bus_req,
  input wire logic [31:0]           bus_rdata,
  input wire logic [31:0]           test_power,
  input wire logic                  bus_trigger,
  input wire logic                  external_port_one_in,
  input wire logic                  external_port_two_in,
  input wire logic [15:0]           average_count,
  input wire logic                  external_port_one_out,
  input wire logic                  external_port_one_oe_n,
  input wire logic                  external_port_two_out,
  input wire logic                  external_port_two_oe_n,
  input wire logic                  measuring,
  input wire logic                  measure_start
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Shadow of the delay setting: a trigger start leads straight into measuring only when no delay is set; a force start always does
  logic delay_zero_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      delay_zero_q <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == tec_pkg::TEC_REG_DELAY) begin
      delay_zero_q <= (bus_req.wdata == 32'h0);
    end
  end

  // Arming and forcing while nothing is in flight
  sequence s_init;
    bus_req.wr && bus_req.addr == tec_pkg::TEC_REG_COMMAND && bus_req.wdata[1] && !measuring && !measure_start;
  endsequence
  sequence s_force;
    bus_req.wr && bus_req.addr == tec_pkg::TEC_REG_COMMAND && bus_req.wdata[0] && !measuring && !measure_start;
  endsequence

  a_force_starts: assert property (s_init ##[1:2] s_force |=> measure_start)
    else $error("force command did not start a measurement");
  a_start_then_meas: assert property (measure_start && delay_zero_q |=> measuring)
    else $error("measuring did not follow start");
  a_start_single: assert property (measure_start |=> !measure_start)
    else $error("start pulse longer than one cycle");
  a_busy_no_start: assert property (measuring |-> !measure_start)
    else $error("start while measuring");
  a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> !measuring && !measure_start && external_port_one_oe_n && external_port_two_oe_n)
    else $error("outputs active after reset");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_drive_one: assert property (external_port_one_out |-> !external_port_one_oe_n)
    else $error("port one high while not driven");
  a_drive_two: assert property (external_port_two_out |-> !external_port_two_oe_n)
    else $error("port two high while not driven");
endmodule // tec_chk

bind tec_trigger_ctrl tec_chk #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) i_tec_chk (
  .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .test_power(test_power),
  .bus_trigger(bus_trigger), .external_port_one_in(external_port_one_in),
  .external_port_two_in(external_port_two_in), .average_count(average_count),
  .external_port_one_out(external_port_one_out), .external_port_one_oe_n(external_port_one_oe_n),
  .external_port_two_out(external_port_two_out), .external_port_two_oe_n(external_port_two_oe_n),
  .measuring(measuring), .measure_start(measure_start));

/* File: tb/tec_trigger_ctrl_test.sv */
// Testbench: register, trigger source, hold-off, master and sync scenarios
`timescale 1ns/1ps
module tec_trigger_ctrl_test;
  logic                  core_clk      = 1'b0;
  logic                  rst           = 1'b1;
  tec_pkg::tec_bus_req_s bus_req       = '0;
  logic                  bus_trigger   = 1'b0;
  logic [15:0]           average_count = 16'h1;
  logic [31:0]           test_power    = 32'h0;
  logic                  far_one_en    = 1'b0;
  logic                  far_one_val   = 1'b0;
  logic [31:0]           bus_rdata;
  logic                  one_in, two_in, one_out, one_oe_n, two_out, two_oe_n, measuring, measure_start, seen;
  int                    bad_count     = 0;
  int                    num_checks    = 0;
  int                    cycles        = 0;
  logic [31:0]           rv [6]        = '{32'h1, 32'h0, 32'h0, 32'h7530, 32'h1, 32'h0};

  tec_trigger_ctrl #(.TICK_CYCLES(4)) i_tec_trigger_ctrl (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .test_power(test_power),
    .bus_trigger(bus_trigger), .external_port_one_in(one_in), .external_port_two_in(two_in),
    .average_count(average_count), .external_port_one_out(one_out), .external_port_one_oe_n(one_oe_n),
    .external_port_two_out(two_out), .external_port_two_oe_n(two_oe_n), .measuring(measuring),
    .measure_start(measure_start));
  tec_far_sensor i_tec_far_sensor (
    .far_one_en(far_one_en), .far_one_val(far_one_val), .far_two_en(1'b0), .far_two_val(1'b0),
    .dut_one_out(one_out), .dut_one_oe_n(one_oe_n), .dut_two_out(two_out), .dut_two_oe_n(two_oe_n),
    .line_one(one_in), .line_two(two_in));

  always #50 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  // Read data is sampled at the edge that closes the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(posedge core_clk);
    chk(bus_rdata & m, exp);
  endtask
  task automatic wait_start(input int n, output logic s);
    s = 1'b0;
    for (int k = 0; k < n && !s; k++) begin
      @(posedge core_clk);
      s = (measure_start === 1'b1);
    end
  endtask
  task automatic arm(input logic [31:0] ctrl);
    wr(tec_pkg::TEC_REG_CTRL, ctrl);
    wr(tec_pkg::TEC_REG_COMMAND, 32'h2);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), rv[i], 32'hffff_ffff);
    rd(8'h20, 32'h0, 32'hffff_ffff);
    chk({30'h0, one_oe_n, two_oe_n}, 32'h3);
    $display("test reset values done");
    wr(tec_pkg::TEC_REG_HOLDOFF, 32'h7ff);
    rd(tec_pkg::TEC_REG_HOLDOFF, 32'h3e8, 32'hffff_ffff);
    wr(tec_pkg::TEC_REG_HYST, 32'h7ff);
    rd(tec_pkg::TEC_REG_HYST, 32'h3e8, 32'hffff_ffff);
    wr(tec_pkg::TEC_REG_LEVEL, 32'h1);
    rd(tec_pkg::TEC_REG_LEVEL, 32'h12c, 32'hffff_ffff);
    wr(tec_pkg::TEC_REG_LEVEL, 32'hffff_ffff);
    rd(tec_pkg::TEC_REG_LEVEL, 32'h5f5_e100, 32'hffff_ffff);
    wr(tec_pkg::TEC_REG_HOLDOFF, 32'h0);
    wr(tec_pkg::TEC_REG_HYST, 32'h0);
    $display("test range limits done");
    average_count <= 16'h3;
    bus_trigger <= 1'b1;
    far_one_en <= 1'b1;
    far_one_val <= 1'b1;
    arm(32'h0);
    wait_start(10, seen);
    chk1(seen, 1'b0);
    wr(tec_pkg::TEC_REG_COMMAND, 32'h1);
    wait_start(3, seen);
    chk1(seen, 1'b1);
    repeat (12) @(posedge core_clk);
    rd(tec_pkg::TEC_REG_STATUS, 32'h0, 32'h3);
    arm(32'h0);
    wr(tec_pkg::TEC_REG_COMMAND, 32'h1);
    wait_start(3, seen);
    chk1(seen, 1'b1);
    repeat (8) @(posedge core_clk);
    rd(tec_pkg::TEC_REG_STATUS, 32'h0, 32'h3);
    bus_trigger <= 1'b0;
    far_one_val <= 1'b0;
    average_count <= 16'h1;
    $display("test hold source done");
    arm(32'h65);
    far_one_val <= 1'b1;
    wait_start(5, seen);
    chk1(seen, 1'b1);
    chk1(two_out, 1'b1);
    chk1(two_oe_n, 1'b0);
    chk1(one_oe_n, 1'b1);
    @(posedge core_clk);
    chk1(two_out, 1'b0);
    repeat (12) @(posedge core_clk);
    far_one_val <= 1'b0;
    arm(32'h75);
    far_one_val <= 1'b1;
    wait_start(6, seen);
    chk1(seen, 1'b0);
    far_one_val <= 1'b0;
    wait_start(5, seen);
    chk1(seen, 1'b1);
    repeat (12) @(posedge core_clk);
    far_one_en <= 1'b0;
    $display("test external slope done");
    wr(tec_pkg::TEC_REG_HOLDOFF, 32'h3);
    average_count <= 16'h2;
    bus_trigger <= 1'b1;
    arm(32'h3);
    wait_start(5, seen);
    chk1(seen, 1'b1);
    wait_start(10, seen);
    chk1(seen, 1'b0);
    wait_start(10, seen);
    chk1(seen, 1'b1);
    bus_trigger <= 1'b0;
    average_count <= 16'h1;
    wr(tec_pkg::TEC_REG_HOLDOFF, 32'h0);
    repeat (12) @(posedge core_clk);
    $display("test hold-off done");
    for (int i = 0; i < 2; i++) begin
      arm(i ? 32'h183 : 32'h83);
      bus_trigger <= 1'b1;
      wait_start(5, seen);
      chk1(seen, 1'b1);
      bus_trigger <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk1(measuring, 1'b1);
      chk1(i ? two_out : one_out, 1'b1);
      chk1(i ? two_oe_n : one_oe_n, 1'b0);
      repeat (12) @(posedge core_clk);
      chk1(i ? two_out : one_out, 1'b0);
    end
    $display("test sync output done");
    wr(tec_pkg::TEC_REG_LEVEL, 32'h1000);
    wr(tec_pkg::TEC_REG_HYST, 32'h64);
    average_count <= 16'h2;
    arm(32'h2);
    test_power <= 32'h1000;
    wait_start(5, seen);
    chk1(seen, 1'b1);
    test_power <= 32'hfc0;
    repeat (2) @(posedge core_clk);
    test_power <= 32'h1000;
    wait_start(10, seen);
    chk1(seen, 1'b0);
    test_power <= 32'hf00;
    repeat (2) @(posedge core_clk);
    test_power <= 32'h1000;
    wait_start(5, seen);
    chk1(seen, 1'b1);
    average_count <= 16'h1;
    repeat (8) @(posedge core_clk);
    arm(32'h1);
    wait_start(3, seen);
    chk1(seen, 1'b1);
    $display("test internal and immediate done");
    test_done();
  end
endmodule // tec_trigger_ctrl_test
